// ===== core/rxmbf_filter_store.sv
// Receive path: shadow capture, filter search, buffer and FIFO store
module rxmbf_filter_store (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// APB register slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Frame decoder
	input wire logic rxValid,
	input wire logic rxChannel,
	input wire logic rxSemOk,
	input wire logic rxSynOk,
	input wire rxmbf_pkg::rxmbf_frame_t rxFrame,
	// Host interrupt
	output logic hostIrq
);
	localparam int NB = rxmbf_pkg::NBUF;
	localparam int IW = rxmbf_pkg::IDX_W;

	// ---------------------------------------------------------------
	// Storage
	// ---------------------------------------------------------------
	rxmbf_pkg::rxmbf_frame_t bufData_ff [NB];
	rxmbf_pkg::rxmbf_bufcfg_t bufCfg_ff [NB];
	rxmbf_pkg::rxmbf_frame_t shadow_ff [rxmbf_pkg::NSHADOW];
	rxmbf_pkg::rxmbf_frame_t cur_ff, pend_ff;
	rxmbf_pkg::rxmbf_state_t state_ff;
	logic [3:0] shValid_ff;
	logic [1:0] shWr_ff, shRd_ff;
	logic [NB-1:0] full_ff;
	logic configMode_ff, locked_ff, pendValid_ff, pendLost_ff;
	logic commitReq_ff, frameLost_ff, curCh_ff, hit_ff;
	logic [IW:0] fifoSize_ff, fifoCnt_ff, idx_ff;
	logic [15:0] midVal_ff, midMask_ff;
	logic [10:0] fifoFid_ff, fifoMask_ff;
	logic [IW-1:0] lockIdx_ff, pendIdx_ff, fifoWr_ff, fifoRd_ff;
	logic [31:0] prdata_ff;

	// Decoded strobes and search terms
	logic [NB-1:0] rxCfgd, match, irqSrc;
	logic [15:0] effMid;
	logic setup, access, bufHit, addrOk, wrEn, selStbds;
	logic rxEnabled, rxAccept, shTake, fifoOk, storeHit, toLocked;
	logic storeBuf, commitNow, fifoPush, fifoPop, lockNow, unlockNow;
	logic ivecValid;
	logic [IW-1:0] bufSel, ivecIdx;
	rxmbf_pkg::rxmbf_bufcfg_t wrCfg;
	logic [1:0] capSlot, takeSlot;
	logic [31:0] rdMux;

	// ---------------------------------------------------------------
	// APB decode
	// ---------------------------------------------------------------
	// Zero wait states; unmapped or unaligned addresses answer with error
	assign setup = psel && !penable;
	assign access = psel && penable;
	assign bufHit = paddr[7:5] == rxmbf_pkg::BUF_REGION;
	assign bufSel = paddr[IW+1:2];
	assign addrOk = paddr[1:0] == 2'h0 &&
		(bufHit || paddr <= rxmbf_pkg::OFS_IVEC);
	assign wrEn = access && pwrite && addrOk;
	assign pready = 1'b1;
	assign pslverr = access && !addrOk;
	assign prdata = prdata_ff;
	assign wrCfg = rxmbf_pkg::rxmbf_bufcfg_t'(pwdata[rxmbf_pkg::BF_CFG_W-1:0]);
	assign selStbds = bufCfg_ff[bufSel].tx && bufCfg_ff[bufSel].dyn &&
		!bufCfg_ff[bufSel].dbl;

	// Lock request is refused while a commit is pending so the held frame lands first
	assign lockNow = wrEn && bufHit && pwdata[rxmbf_pkg::BF_LOCK] &&
		!locked_ff && !commitReq_ff && !bufCfg_ff[bufSel].tx;
	assign unlockNow = wrEn && bufHit && !pwdata[rxmbf_pkg::BF_LOCK] &&
		locked_ff && lockIdx_ff == bufSel;

	// ---------------------------------------------------------------
	// Per-buffer filter, flag and interrupt logic
	// ---------------------------------------------------------------
	// Payload too short to carry the id: filter on the default value
	assign effMid = (cur_ff.len >= rxmbf_pkg::MID_MIN_LEN) ? cur_ff.mid :
		rxmbf_pkg::MID_DEFAULT;

	genvar g;
	for (g = 0; g < NB; g++) begin : gBuf
		// FIFO entries and disabled buffers take no part in the search
		assign rxCfgd[g] = !bufCfg_ff[g].tx &&
			bufCfg_ff[g].fid != rxmbf_pkg::FID_NONE &&
			(IW+1)'(g) >= fifoSize_ff;
		assign match[g] = rxCfgd[g] && bufCfg_ff[g].fid == cur_ff.fid &&
			(curCh_ff ? bufCfg_ff[g].chB : bufCfg_ff[g].chA) &&
			(!bufCfg_ff[g].useMid ||
			((effMid ^ midVal_ff) & midMask_ff) == 16'h0000);
		assign irqSrc[g] = full_ff[g] && bufCfg_ff[g].irqEn;

		// Full flag: a store in the clearing cycle wins over the clear
		always_ff @(posedge clk) begin
			if (reset) begin
				full_ff[g] <= 1'b0;
			end else if ((storeBuf && idx_ff == (IW+1)'(g)) ||
				(commitNow && pendIdx_ff == IW'(g))) begin
				full_ff[g] <= 1'b1;
			end else if (wrEn && bufHit && bufSel == IW'(g) &&
				pwdata[rxmbf_pkg::BF_FULL]) begin
				full_ff[g] <= 1'b0;
			end
		end
	end

	// All unmasked full flags share one host line
	assign hostIrq = |irqSrc;

	// Lowest flagged and enabled buffer for the vector register
	always_comb begin
		ivecValid = 1'b0;
		ivecIdx = '0;
		for (int i = NB - 1; i >= 0; i--) begin
			if (irqSrc[i]) begin
				ivecValid = 1'b1;
				ivecIdx = IW'(i);
			end
		end
	end

	// ---------------------------------------------------------------
	// Configuration registers
	// ---------------------------------------------------------------
	// Mode, FIFO size and global filters; sizes and filters only in config
	always_ff @(posedge clk) begin
		if (reset) begin
			configMode_ff <= rxmbf_pkg::CONFIG_RST;
			fifoSize_ff <= '0;
			midVal_ff <= 16'h0000;
			midMask_ff <= 16'h0000;
			fifoFid_ff <= 11'h000;
			fifoMask_ff <= 11'h000;
		end else if (wrEn && configMode_ff) begin
			if (paddr == rxmbf_pkg::OFS_CTRL) begin
				configMode_ff <= pwdata[rxmbf_pkg::CTRL_CONFIG];
				fifoSize_ff <= (pwdata[rxmbf_pkg::CTRL_FSIZE_LO +: IW+1] >
					(IW+1)'(NB)) ? (IW+1)'(NB) :
					pwdata[rxmbf_pkg::CTRL_FSIZE_LO +: IW+1];
			end
			if (paddr == rxmbf_pkg::OFS_MIDF) begin
				midVal_ff <= pwdata[15:0];
				midMask_ff <= pwdata[rxmbf_pkg::FILT_MASK_LO +: 16];
			end
			if (paddr == rxmbf_pkg::OFS_FIFOF) begin
				fifoFid_ff <= pwdata[10:0];
				fifoMask_ff <= pwdata[rxmbf_pkg::FILT_MASK_LO +: 11];
			end
		end else if (wrEn && paddr == rxmbf_pkg::OFS_CTRL) begin
			configMode_ff <= pwdata[rxmbf_pkg::CTRL_CONFIG];
		end
	end

	// Buffer setup: free in config; in normal mode only the frame id and
	// interrupt enable of a dynamic single transmit buffer may change
	always_ff @(posedge clk) begin
		if (reset) begin
			for (int i = 0; i < NB; i++) begin
				bufCfg_ff[i] <= '0;
			end
		end else if (wrEn && bufHit) begin
			if (configMode_ff) begin
				bufCfg_ff[bufSel] <= wrCfg;
			end else if (selStbds) begin
				bufCfg_ff[bufSel].fid <= wrCfg.fid;
				bufCfg_ff[bufSel].irqEn <= wrCfg.irqEn;
			end
		end
	end

	// Lock handshake: one buffer at a time, granted on the write edge
	always_ff @(posedge clk) begin
		if (reset) begin
			locked_ff <= 1'b0;
			lockIdx_ff <= '0;
		end else if (lockNow) begin
			locked_ff <= 1'b1;
			lockIdx_ff <= bufSel;
		end else if (unlockNow) begin
			locked_ff <= 1'b0;
		end
	end

	// Frame lost error: set on commit of an overwritten pending frame
	always_ff @(posedge clk) begin
		if (reset) begin
			frameLost_ff <= 1'b0;
		end else if (commitNow && pendLost_ff) begin
			frameLost_ff <= 1'b1;
		end else if (wrEn && paddr == rxmbf_pkg::OFS_ERR &&
			pwdata[rxmbf_pkg::ERR_LOST]) begin
			frameLost_ff <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Shadow capture
	// ---------------------------------------------------------------
	// Receiving is off in config and when nothing could take a frame
	assign rxEnabled = (|rxCfgd) || fifoSize_ff != '0;
	assign rxAccept = rxValid && rxSemOk && rxSynOk && !configMode_ff &&
		rxEnabled;
	assign capSlot = {rxChannel, shWr_ff[rxChannel]};
	assign takeSlot = shValid_ff[{1'b0, shRd_ff[0]}] ?
		{1'b0, shRd_ff[0]} : {1'b1, shRd_ff[1]};
	assign shTake = state_ff == rxmbf_pkg::ST_IDLE && !commitReq_ff &&
		shValid_ff[takeSlot];

	// Two-entry in-order queue per channel; a third frame is dropped
	always_ff @(posedge clk) begin
		if (reset) begin
			shValid_ff <= 4'h0;
			shWr_ff <= 2'h0;
			shRd_ff <= 2'h0;
		end else begin
			if (shTake) begin
				shValid_ff[takeSlot] <= 1'b0;
				shRd_ff[takeSlot[1]] <= !shRd_ff[takeSlot[1]];
			end
			if (rxAccept && !shValid_ff[capSlot]) begin
				shadow_ff[capSlot] <= rxFrame;
				shValid_ff[capSlot] <= 1'b1;
				shWr_ff[rxChannel] <= !shWr_ff[rxChannel];
			end
		end
	end

	// ---------------------------------------------------------------
	// Search engine
	// ---------------------------------------------------------------
	assign fifoOk = fifoSize_ff != '0 && fifoCnt_ff < fifoSize_ff &&
		((cur_ff.fid ^ fifoFid_ff) & fifoMask_ff) == 11'h000;
	assign storeHit = state_ff == rxmbf_pkg::ST_STORE && hit_ff;
	assign toLocked = storeHit && locked_ff &&
		lockIdx_ff == idx_ff[IW-1:0];
	assign storeBuf = storeHit && !toLocked;
	assign commitNow = state_ff == rxmbf_pkg::ST_IDLE && commitReq_ff &&
		pendValid_ff;
	assign fifoPush = state_ff == rxmbf_pkg::ST_STORE && !hit_ff &&
		fifoOk;

	// One buffer checked per cycle, so a frame is placed within NBUF+3
	// cycles of capture, far inside the 16 microtick slot margin
	always_ff @(posedge clk) begin
		if (reset) begin
			state_ff <= rxmbf_pkg::ST_IDLE;
			cur_ff <= '0;
			curCh_ff <= 1'b0;
			idx_ff <= '0;
			hit_ff <= 1'b0;
			pend_ff <= '0;
			pendIdx_ff <= '0;
			pendValid_ff <= 1'b0;
			pendLost_ff <= 1'b0;
			commitReq_ff <= 1'b0;
		end else begin
			if (unlockNow) begin
				commitReq_ff <= 1'b1;
			end
			unique case (state_ff)
				rxmbf_pkg::ST_IDLE: begin
					if (commitReq_ff) begin
						commitReq_ff <= 1'b0;
						pendValid_ff <= 1'b0;
						pendLost_ff <= 1'b0;
					end else if (shTake) begin
						cur_ff <= shadow_ff[takeSlot];
						curCh_ff <= takeSlot[1];
						idx_ff <= fifoSize_ff;
						state_ff <= rxmbf_pkg::ST_SEARCH;
					end
				end
				rxmbf_pkg::ST_SEARCH: begin
					if (idx_ff == (IW+1)'(NB)) begin
						hit_ff <= 1'b0;
						state_ff <= rxmbf_pkg::ST_STORE;
					end else if (match[idx_ff[IW-1:0]]) begin
						hit_ff <= 1'b1;
						state_ff <= rxmbf_pkg::ST_STORE;
					end else begin
						idx_ff <= idx_ff + (IW+1)'(1);
					end
				end
				rxmbf_pkg::ST_STORE: begin
					if (toLocked) begin
						pend_ff <= cur_ff;
						pendIdx_ff <= idx_ff[IW-1:0];
						pendValid_ff <= 1'b1;
						pendLost_ff <= pendValid_ff;
					end
					state_ff <= rxmbf_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Message store and FIFO
	// ---------------------------------------------------------------
	// Single writer of the frame memory; the engine state and the hit
	// flag keep the three sources apart
	always_ff @(posedge clk) begin
		if (reset) begin
			for (int i = 0; i < NB; i++) begin
				bufData_ff[i] <= '0;
			end
		end else if (commitNow) begin
			bufData_ff[pendIdx_ff] <= pend_ff;
		end else if (storeBuf) begin
			bufData_ff[idx_ff[IW-1:0]] <= cur_ff;
		end else if (fifoPush) begin
			bufData_ff[fifoWr_ff] <= cur_ff;
		end
	end

	// FIFO occupies entries 0 to size-1 as a ring; reads pop the head
	assign fifoPop = access && !pwrite &&
		paddr == rxmbf_pkg::OFS_FIFODATA && fifoCnt_ff != '0;

	always_ff @(posedge clk) begin
		if (reset) begin
			fifoWr_ff <= '0;
			fifoRd_ff <= '0;
			fifoCnt_ff <= '0;
		end else begin
			if (fifoPush) begin
				fifoWr_ff <= ({1'b0, fifoWr_ff} + (IW+1)'(1) == fifoSize_ff) ?
					'0 : fifoWr_ff + IW'(1);
			end
			if (fifoPop) begin
				fifoRd_ff <= ({1'b0, fifoRd_ff} + (IW+1)'(1) == fifoSize_ff) ?
					'0 : fifoRd_ff + IW'(1);
			end
			if (fifoPush && !fifoPop) begin
				fifoCnt_ff <= fifoCnt_ff + (IW+1)'(1);
			end else if (fifoPop && !fifoPush) begin
				fifoCnt_ff <= fifoCnt_ff - (IW+1)'(1);
			end
		end
	end

	// ---------------------------------------------------------------
	// Read data
	// ---------------------------------------------------------------
	// Active buffer views show data only while a lock is held
	always_comb begin
		rdMux = 32'h00000000;
		if (bufHit) begin
			rdMux[rxmbf_pkg::BF_CFG_W-1:0] = bufCfg_ff[bufSel];
			rdMux[rxmbf_pkg::BF_LOCK] = locked_ff && lockIdx_ff == bufSel;
			rdMux[rxmbf_pkg::BF_FULL] = full_ff[bufSel];
		end else begin
			case (paddr)
				rxmbf_pkg::OFS_CTRL: begin
					rdMux[rxmbf_pkg::CTRL_CONFIG] = configMode_ff;
					rdMux[rxmbf_pkg::CTRL_FSIZE_LO +: IW+1] = fifoSize_ff;
				end
				rxmbf_pkg::OFS_ERR: rdMux[rxmbf_pkg::ERR_LOST] = frameLost_ff;
				rxmbf_pkg::OFS_MIDF: rdMux = {midMask_ff, midVal_ff};
				rxmbf_pkg::OFS_FIFOF: begin
					rdMux[10:0] = fifoFid_ff;
					rdMux[rxmbf_pkg::FILT_MASK_LO +: 11] = fifoMask_ff;
				end
				rxmbf_pkg::OFS_ACTDATA: begin
					if (locked_ff) rdMux = bufData_ff[lockIdx_ff].data;
				end
				rxmbf_pkg::OFS_ACTHDR: begin
					if (locked_ff) begin
						rdMux[23:0] = {bufData_ff[lockIdx_ff].cyc,
							bufData_ff[lockIdx_ff].len,
							bufData_ff[lockIdx_ff].fid};
					end
				end
				rxmbf_pkg::OFS_FIFODATA: begin
					if (fifoCnt_ff != '0) rdMux = bufData_ff[fifoRd_ff].data;
				end
				rxmbf_pkg::OFS_FIFOSTAT: rdMux[IW:0] = fifoCnt_ff;
				rxmbf_pkg::OFS_IVEC: begin
					rdMux[IW-1:0] = ivecIdx;
					rdMux[rxmbf_pkg::IVEC_VALID] = ivecValid;
				end
				default: rdMux = 32'h00000000;
			endcase
		end
	end

	// Read data is sampled in the setup cycle and held through access;
	// refused addresses read zero so no buffer leaks through an alias
	always_ff @(posedge clk) begin
		if (reset) begin
			prdata_ff <= 32'h00000000;
		end else if (setup) begin
			prdata_ff <= addrOk ? rdMux : 32'h00000000;
		end
	end
endmodule : rxmbf_filter_store

// ===== core/rxmbf_pkg.sv
// Constants and types of the receive buffer filter and store block
// ---------------------------------------------------------------------
// ---------------------------------------------------------------------
package rxmbf_pkg;
	// Sizes
	localparam int NBUF = 8;
	localparam int IDX_W = 3;
	localparam int NSHADOW = 4;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_ERR = 8'h04;
	localparam logic [7:0] OFS_MIDF = 8'h08;
	localparam logic [7:0] OFS_FIFOF = 8'h0c;
	localparam logic [7:0] OFS_ACTDATA = 8'h10;
	localparam logic [7:0] OFS_ACTHDR = 8'h14;
	localparam logic [7:0] OFS_FIFODATA = 8'h18;
	localparam logic [7:0] OFS_FIFOSTAT = 8'h1c;
	localparam logic [7:0] OFS_IVEC = 8'h20;
	localparam logic [2:0] BUF_REGION = 3'h2;
	// Field positions
	localparam int CTRL_CONFIG = 0;
	localparam int CTRL_FSIZE_LO = 8;
	localparam int ERR_LOST = 0;
	localparam int IVEC_VALID = 8;
	localparam int FILT_MASK_LO = 16;
	localparam int BF_CFG_W = 18;
	localparam int BF_LOCK = 24;
	localparam int BF_FULL = 25;
	// Reset values and filter defaults
	localparam logic CONFIG_RST = 1'b1;
	localparam logic [6:0] MID_MIN_LEN = 7'h01;
	localparam logic [15:0] MID_DEFAULT = 16'h0000;
	localparam logic [10:0] FID_NONE = 11'h000;

	typedef struct packed {
		logic [5:0] cyc;
		logic [6:0] len;
		logic [10:0] fid;
		logic [15:0] mid;
		logic [31:0] data;
	} rxmbf_frame_t;

	typedef struct packed {
		logic [10:0] fid;
		logic useMid;
		logic dbl;
		logic dyn;
		logic chB;
		logic chA;
		logic irqEn;
		logic tx;
	} rxmbf_bufcfg_t;

	typedef enum logic [1:0] {ST_IDLE, ST_SEARCH, ST_STORE} rxmbf_state_t;
endpackage : rxmbf_pkg

// ===== verification/rxmbf_filter_store_props.sv
// Concurrent checks on the ports of the receive filter and store block
module rxmbf_filter_store_props (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// APB register slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Frame decoder
	input wire logic rxValid,
	input wire logic rxChannel,
	input wire logic rxSemOk,
	input wire logic rxSynOk,
	input wire rxmbf_pkg::rxmbf_frame_t rxFrame,
	// Host interrupt
	input wire logic hostIrq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	logic wrAcc;
	logic [5:0] sinceEv_ff;
	// A write access is the only way the host clears a full or error flag
	assign wrAcc = psel && penable && pwrite;
	// Cycles since the last frame or write; a rise needs a recent cause
	always_ff @(posedge clk) begin
		if (reset || wrAcc || (rxValid && rxSemOk && rxSynOk))
			sinceEv_ff <= 6'h00;
		else if (sinceEv_ff != 6'h3f)
			sinceEv_ff <= sinceEv_ff + 6'h01;
	end
	// ---------------------------------------------------------------
	// Port relations
	// ---------------------------------------------------------------
	a_idle_rdata_hold: assert property (disable iff (reset)
		!psel && !$past(reset) |-> $stable(prdata))
		else $error("read data moved while bus idle");
	a_err_access_only: assert property (disable iff (reset)
		pslverr |-> psel && penable)
		else $error("slave error outside access phase");
	a_unaligned_refused: assert property (disable iff (reset)
		psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
		else $error("unaligned access not refused");
	a_ctrl_mapped: assert property (disable iff (reset)
		psel && penable && paddr == rxmbf_pkg::OFS_CTRL |-> !pslverr)
		else $error("control register refused");
	a_err_read_zero: assert property (disable iff (reset)
		psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
		else $error("refused read returned data");
	a_reset_quiet: assert property (reset |=> !hostIrq && prdata == 32'h0)
		else $error("outputs not cleared by reset");
	a_irq_has_cause: assert property (disable iff (reset)
		$rose(hostIrq) |-> sinceEv_ff != 6'h3f)
		else $error("interrupt rose with no frame or write");
	a_irq_clr_write: assert property (disable iff (reset)
		$fell(hostIrq) |-> $past(wrAcc) || $past(reset))
		else $error("interrupt fell without host write");
	a_ready_no_wait: assert property (disable iff (reset)
		psel && penable |-> pready)
		else $error("access phase without ready");
endmodule : rxmbf_filter_store_props

bind rxmbf_filter_store rxmbf_filter_store_props props (.clk(clk),
	.reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .rxValid(rxValid), .rxChannel(rxChannel),
	.rxSemOk(rxSemOk), .rxSynOk(rxSynOk), .rxFrame(rxFrame),
	.hostIrq(hostIrq));

// ===== verification/rxmbf_frame_src.sv
// Frame decoder model that hands received frames to the block
module rxmbf_frame_src (
	// Clock
	input wire logic clk,
	// Decoded frame
	output logic rxValid,
	output logic rxChannel,
	output logic rxSemOk,
	output logic rxSynOk,
	output rxmbf_pkg::rxmbf_frame_t rxFrame
);
	timeunit 1ns;
	timeprecision 1ps;
	// Quiet at start
	initial begin
		rxValid = 1'b0;
		rxChannel = 1'b0;
		rxSemOk = 1'b0;
		rxSynOk = 1'b0;
		rxFrame = '0;
	end
	// One single-cycle pulse; afterwards the lines carry the inverse, so a
	// block that samples outside the pulse sees garbage, not a stale frame
	task automatic send(input logic ch, input logic ok,
		input rxmbf_pkg::rxmbf_frame_t f);
		@(posedge clk);
		rxValid <= 1'b1;
		rxChannel <= ch;
		rxSemOk <= ok;
		rxSynOk <= 1'b1;
		rxFrame <= f;
		@(posedge clk);
		rxValid <= 1'b0;
		rxChannel <= ~ch;
		rxSemOk <= ~ok;
		rxSynOk <= 1'b0;
		rxFrame <= ~f;
	endtask : send
endmodule : rxmbf_frame_src

// ===== verification/rxmbf_filter_store_test.sv
// Self-checking bench of the receive buffer filter and store block
`define CHK(a, b) begin testsRun++; if ((a) !== (b)) begin failCount++; \
	$display("FAIL t=%0t got=%h exp=%h", $time, (a), (b)); end end
module rxmbf_filter_store_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] B1 = 32'h0000_0286;
	localparam logic [31:0] B3 = 32'h0000_04ce;
	localparam logic [31:0] B4 = 32'h0000_058c;
	localparam logic [31:0] FL = 32'h0200_0000;
	localparam logic [31:0] ALL = 32'hffff_ffff;
	logic clk, reset, psel, penable, pwrite, pready, pslverr;
	logic rxValid, rxChannel, rxSemOk, rxSynOk, hostIrq;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, seed, d1, d3;
	logic [64:0] note;
	logic [64:0] noteQ[$];
	rxmbf_pkg::rxmbf_frame_t rxFrame;
	int failCount, testsRun;

	rxmbf_filter_store dut (.clk(clk), .reset(reset), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rxValid(rxValid), .rxChannel(rxChannel), .rxSemOk(rxSemOk),
		.rxSynOk(rxSynOk), .rxFrame(rxFrame), .hostIrq(hostIrq));
	rxmbf_frame_src src (.clk(clk), .rxValid(rxValid),
		.rxChannel(rxChannel), .rxSemOk(rxSemOk), .rxSynOk(rxSynOk),
		.rxFrame(rxFrame));

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic rxmbf_pkg::rxmbf_frame_t mk(input logic [10:0] f,
		input logic [6:0] l, input logic [15:0] m, input logic [31:0] d);
		mk = '{cyc: 6'h00, len: l, fid: f, mid: m, data: d};
	endfunction : mk
	// One APB transfer; the request holds until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		apb(1'b1, a, d, r);
	endtask : wr
	// Reads note {error, mask, value}; the monitor does the compare
	task automatic rd(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e, input logic err);
		logic [31:0] r;
		noteQ.push_back({err, m, e});
		apb(1'b0, a, 32'h0, r);
	endtask : rd
	// Lock request, then poll the lock bit under a bounded count
	task automatic lockBuf(input logic [7:0] a, input logic [31:0] cfg);
		logic [31:0] r;
		int n;
		n = 0;
		r = 32'h0;
		wr(a, cfg | 32'h0100_0000);
		while (r[24] !== 1'b1 && n < 20) begin
			noteQ.push_back({1'b0, 32'h0, 32'h0});
			apb(1'b0, a, 32'h0, r);
			n++;
		end
		`CHK(r[24], 1'b1)
	endtask : lockBuf
	// Longer than the worst engine latency of an idle search
	task automatic settle;
		repeat (12) @(posedge clk);
		#1;
	endtask : settle
	task automatic endSim;
		$display("comparisons %0d mismatches %0d", testsRun, failCount);
		if (failCount == 0 && testsRun > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : endSim

	// Clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// Watchdog far beyond the expected run length
	initial begin
		repeat (5000) @(posedge clk);
		failCount++;
		endSim;
	end
	// Oldest read note against what the slave answers at the access edge
	always @(posedge clk) begin
		if (psel && penable && !pwrite && pready) begin
			note = noteQ.pop_front();
			`CHK({pslverr, prdata & note[63:32]}, {note[64], note[31:0]})
		end
	end

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	initial begin
		reset = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		failCount = 0;
		testsRun = 0;
		seed = 32'h875d178e;
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		rd(8'h00, ALL, 32'h0000_0001, 1'b0);
		rd(8'h24, ALL, 32'h0, 1'b1);
		rd(8'h42, ALL, 32'h0, 1'b1);
		// One FIFO entry; buffer 0 sits in it, so its filter is never used
		wr(8'h00, 32'h0000_0101);
		wr(8'h40, B1);
		wr(8'h44, B1);
		wr(8'h48, B1);
		wr(8'h4c, B3);
		wr(8'h50, B4);
		wr(8'h54, 32'h0000_0191);
		wr(8'h08, 32'hffff_0000);
		wr(8'h0c, 32'h07ff_0007);
		wr(8'h00, 32'h0000_0100);
		// Invalid frame is dropped, then a valid one lands in buffer 1
		src.send(1'b0, 1'b0, mk(11'h005, 7'h08, 16'h0, seed));
		settle;
		rd(8'h44, FL, 32'h0, 1'b0);
		d1 = lfsr(seed);
		src.send(1'b0, 1'b1, mk(11'h005, 7'h08, 16'h0, d1));
		settle;
		`CHK(hostIrq, 1'b1)
		rd(8'h44, FL, FL, 1'b0);
		rd(8'h48, FL, 32'h0, 1'b0);
		rd(8'h1c, ALL, 32'h0, 1'b0);
		rd(8'h20, 32'h0000_01ff, 32'h0000_0101, 1'b0);
		rd(8'h46, ALL, 32'h0, 1'b1);
		// Locked target: two frames wait, the newer wins on unlock
		lockBuf(8'h44, B1);
		rd(8'h10, ALL, d1, 1'b0);
		seed = lfsr(d1);
		src.send(1'b0, 1'b1, mk(11'h005, 7'h08, 16'h0, seed));
		src.send(1'b1, 1'b1, mk(11'h00b, 7'h08, 16'h0, seed));
		settle;
		d3 = lfsr(seed);
		src.send(1'b0, 1'b1, mk(11'h005, 7'h08, 16'h0, d3));
		settle;
		rd(8'h10, ALL, d1, 1'b0);
		rd(8'h50, FL, FL, 1'b0);
		wr(8'h44, B1);
		settle;
		rd(8'h04, 32'h1, 32'h1, 1'b0);
		lockBuf(8'h44, B1);
		rd(8'h10, ALL, d3, 1'b0);
		wr(8'h44, B1);
		wr(8'h04, 32'h1);
		wr(8'h44, B1 | FL);
		rd(8'h04, 32'h1, 32'h0, 1'b0);
		rd(8'h44, FL, 32'h0, 1'b0);
		#1;
		`CHK(hostIrq, 1'b0)
		// Short payload filters with message id zero
		seed = lfsr(d3);
		src.send(1'b1, 1'b1, mk(11'h009, 7'h01, 16'h1234, seed));
		settle;
		rd(8'h4c, FL, 32'h0, 1'b0);
		rd(8'h1c, ALL, 32'h0, 1'b0);
		src.send(1'b1, 1'b1, mk(11'h009, 7'h00, 16'h1234, seed));
		settle;
		`CHK(hostIrq, 1'b1)
		rd(8'h4c, FL, FL, 1'b0);
		wr(8'h4c, B3 | FL);
		// No buffer match: the FIFO filter takes it
		seed = lfsr(seed);
		src.send(1'b1, 1'b1, mk(11'h007, 7'h08, 16'h0, seed));
		settle;
		rd(8'h1c, ALL, 32'h1, 1'b0);
		rd(8'h18, ALL, seed, 1'b0);
		rd(8'h1c, ALL, 32'h0, 1'b0);
		// Normal mode: FIFO size and receive filters refuse changes
		wr(8'h00, 32'h0000_0300);
		rd(8'h00, 32'h0000_0f01, 32'h0000_0100, 1'b0);
		wr(8'h50, 32'h0000_0684);
		rd(8'h50, 32'h0003_ffff, B4, 1'b0);
		wr(8'h54, 32'h0000_021a);
		rd(8'h54, 32'h0003_ffff, 32'h0000_0213, 1'b0);
		repeat (3) @(posedge clk);
		`CHK(noteQ.size(), 0)
		endSim;
	end
endmodule : rxmbf_filter_store_test
